/* File: data_xfer_core.sv */
`timescale 1ns/1ns
// Contract
// - Five single-bit flags, set one, reset zero
// - Zero flag set when result is zero
// - Sign flag copies result top bit
// - Parity flag set on even parity
// - Carry flag set on carry or borrow
// - Aux carry set on bit 3 carry
// - Aux carry updated by single-byte arithmetic, logic
// - Register field: 111 A, 000..101 B..L
// - Pair field: BC, DE, HL, stack pointer
// - Data transfers never alter any flag
// - Register move copies source, five states
// - Memory load via HL, seven states
// - Memory store writes register via HL
// - Immediate move loads byte two, seven states
// - Immediate to memory via HL, ten states
// - Pair immediate: byte three high, two low
// - Direct accumulator load, thirteen states
// - Direct accumulator store, thirteen states
// - Direct HL load: L then H
// - Direct HL store: L then H
// - Indirect accumulator load, BC or DE only
// - Indirect accumulator store, BC or DE only
module data_xfer_core
  import xfer_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Instruction start: opcode taken when start and idle
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  output logic             busy,
  output logic             done,
  output logic             illegal,
  // Memory port, byte wide, read data in the same cycle
  output logic [15:0]      mem_addr,
  output logic             mem_rd,
  output logic             mem_wr,
  output logic [7:0]       mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  // Flag update request from the arithmetic side
  input  wire logic        alu_req,
  input  wire logic [7:0]  alu_a,
  input  wire logic [7:0]  alu_b,
  input  wire logic [1:0]  alu_op,
  input  wire logic [4:0]  alu_mask,
  // Visible state
  output logic [7:0]       flags,
  output logic [7:0]       acc,
  output logic [15:0]      pair_bc,
  output logic [15:0]      pair_de,
  output logic [15:0]      pair_hl,
  output logic [15:0]      stack_pointer,
  output logic [3:0]       states
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_q1_ff, rst_q2_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_q1_ff <= 1'b0;
      rst_q2_ff <= 1'b0;
    end else begin
      rst_q1_ff <= 1'b1;
      rst_q2_ff <= rst_q1_ff;
    end
  end
  wire rst_n = rst_q2_ff;

  // ----------------------------------------
  // Register file and decode
  // ----------------------------------------
  typedef enum logic [2:0] {S_IDLE, S_B2, S_B3, S_MEM1, S_MEM2, S_DONE} state_t;
  state_t      st_ff;
  logic [7:0]  rf_ff [8];                     // Index 6 unused: memory operand
  logic [7:0]  op_ff, b2_ff, b3_ff;
  logic [15:0] stk_ff;
  logic [7:0]  flags_ff;
  logic [3:0]  states_ff;

  // Register field read; 110 is never a register
  function automatic logic [7:0] rd_reg(input logic [2:0] f, input logic [7:0] r [8]);
    return (f == REG_MEM) ? 8'h00 : r[f];
  endfunction

  wire [1:0]  grp      = op_ff[7:6];
  wire [2:0]  dest_reg_field = op_ff[5:3];
  wire [2:0]  src_reg_field  = op_ff[2:0];
  wire [1:0]  pair_select_field = op_ff[5:4];
  wire [15:0] hl_addr  = {rf_ff[REG_H], rf_ff[REG_L]};
  wire [15:0] dir_addr = {b3_ff, b2_ff};
  wire        is_move  = grp == GRP_MOVE && op_ff != OP_STOP;
  wire        mv_load  = is_move && src_reg_field == REG_MEM;
  wire        mv_store = is_move && dest_reg_field == REG_MEM;
  wire        is_imm   = grp == GRP_LOW && src_reg_field == LOW_IMM;
  wire        is_pair_imm = grp == GRP_LOW && op_ff[3:0] == LOW_PAIR;
  wire        is_ind_ld = grp == GRP_LOW && op_ff[3:0] == LOW_IND_LD && !op_ff[5];
  wire        is_ind_st = grp == GRP_LOW && op_ff[3:0] == LOW_IND_ST && !op_ff[5];
  wire        is_dir_ld = op_ff == OP_DIR_LD;
  wire        is_dir_st = op_ff == OP_DIR_ST;
  wire        is_hl_ld  = op_ff == OP_HL_LD;
  wire        is_hl_st  = op_ff == OP_HL_ST;
  wire        need_b2  = is_imm | is_pair_imm | is_dir_ld | is_dir_st | is_hl_ld | is_hl_st;
  wire        need_b3  = is_pair_imm | is_dir_ld | is_dir_st | is_hl_ld | is_hl_st;
  wire        need_mem = mv_load | mv_store | (is_imm && dest_reg_field == REG_MEM)
                         | is_ind_ld | is_ind_st | is_dir_ld | is_dir_st | is_hl_ld | is_hl_st;
  wire        valid_op = is_move | need_b2 | is_ind_ld | is_ind_st;
  wire [15:0] ind_addr = pair_select_field == PAIR_BC
                         ? {rf_ff[REG_B], rf_ff[REG_C]} : {rf_ff[REG_D], rf_ff[REG_E]};
  wire        mem_is_wr = mv_store | is_imm | is_ind_st | is_dir_st | is_hl_st;

  // State counts per form
  wire [3:0] st_count = (is_dir_ld | is_dir_st) ? ST_FOUR :
                        (is_pair_imm | (is_imm && dest_reg_field == REG_MEM)) ? ST_THREE :
                        (mv_load | mv_store | is_imm | is_ind_ld | is_ind_st) ? ST_TWO_CYC :
                        (is_hl_ld | is_hl_st) ? ST_HL_DIR[3:0] : ST_MOVE_RR;

  // ----------------------------------------
  // Memory port decode
  // ----------------------------------------
  wire        in_mem   = st_ff == S_MEM1 || st_ff == S_MEM2;
  wire        second   = st_ff == S_MEM2;
  wire [15:0] base_addr = (is_ind_ld | is_ind_st) ? ind_addr :
                          (is_dir_ld | is_dir_st | is_hl_ld | is_hl_st) ? dir_addr : hl_addr;
  wire [15:0] cur_addr = base_addr + {15'h0000, second};
  wire [7:0]  wr_byte  = is_imm ? b2_ff :
                         (is_dir_st | is_ind_st) ? rf_ff[REG_A] :
                         is_hl_st ? (second ? rf_ff[REG_H] : rf_ff[REG_L]) :
                         rd_reg(src_reg_field, rf_ff);
  wire        two_mem  = is_hl_ld | is_hl_st;

  assign mem_addr  = cur_addr;
  assign mem_rd    = in_mem && !mem_is_wr;
  assign mem_wr    = in_mem && mem_is_wr;
  assign mem_wdata = wr_byte;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      S_IDLE: nxt_st = start ? S_B2 : S_IDLE;
      S_B2:   nxt_st = !valid_op ? S_DONE : need_b3 ? S_B3 : need_mem ? S_MEM1 : S_DONE;
      S_B3:   nxt_st = need_mem ? S_MEM1 : S_DONE;
      S_MEM1: nxt_st = two_mem ? S_MEM2 : S_DONE;
      S_MEM2: nxt_st = S_DONE;
      S_DONE: nxt_st = S_IDLE;
      default: nxt_st = S_IDLE;
    endcase
  end

  // Operand bytes arrive on mem_rdata in the fetch states
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= S_IDLE;
      op_ff <= 8'h00;
      b2_ff <= 8'h00;
      b3_ff <= 8'h00;
      states_ff <= 4'h0;
    end else begin
      st_ff <= nxt_st;
      if (st_ff == S_IDLE && start) op_ff <= opcode;
      if (st_ff == S_B2 && need_b2) b2_ff <= mem_rdata;
      if (st_ff == S_B3) b3_ff <= mem_rdata;
      if (st_ff == S_B2) states_ff <= st_count;
    end
  end

  // Register writes; loads take data present in the memory state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) rf_ff[i] <= 8'h00;
      stk_ff <= 16'h0000;
    end else if (st_ff == S_DONE || in_mem) begin
      if (in_mem && mv_load) rf_ff[dest_reg_field] <= mem_rdata;
      if (in_mem && (is_dir_ld | is_ind_ld)) rf_ff[REG_A] <= mem_rdata;
      if (in_mem && is_hl_ld) rf_ff[second ? REG_H : REG_L] <= mem_rdata;
      if (st_ff == S_DONE && is_move && !mv_load && !mv_store)
        rf_ff[dest_reg_field] <= rd_reg(src_reg_field, rf_ff);
      if (st_ff == S_DONE && is_imm && dest_reg_field != REG_MEM)
        rf_ff[dest_reg_field] <= b2_ff;
      if (st_ff == S_DONE && is_pair_imm) begin
        case (pair_select_field)
          PAIR_BC: begin rf_ff[REG_B] <= b3_ff; rf_ff[REG_C] <= b2_ff; end
          PAIR_DE: begin rf_ff[REG_D] <= b3_ff; rf_ff[REG_E] <= b2_ff; end
          PAIR_HL: begin rf_ff[REG_H] <= b3_ff; rf_ff[REG_L] <= b2_ff; end
          default: stk_ff <= {b3_ff, b2_ff};
        endcase
      end
    end
  end

  // ----------------------------------------
  // Flags: only the arithmetic side updates them
  // ----------------------------------------
  wire [8:0] sum9  = alu_op[0] ? {1'b0, alu_a} - {1'b0, alu_b} : {1'b0, alu_a} + {1'b0, alu_b};
  // Subtraction adds the complement, so bit 4 is the true carry out of bit 3
  wire [4:0] nib5  = alu_op[0] ? {1'b0, alu_a[3:0]} + {1'b0, ~alu_b[3:0]} + 5'h01
                               : {1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]};
  wire [7:0] res   = alu_op[1] ? (alu_a & alu_b) : sum9[7:0];
  wire [7:0] calc;
  assign calc[FL_ZERO]  = res == 8'h00;
  assign calc[FL_SIGN]  = res[7];
  assign calc[FL_PAR]   = ~^res;
  assign calc[FL_CARRY] = alu_op[1] ? 1'b0 : sum9[8];
  assign calc[FL_AUX]   = alu_op[1] ? 1'b0 : nib5[4];
  assign calc[5] = 1'b0;
  assign calc[3] = 1'b0;
  assign calc[1] = 1'b1;
  // Mask bits placed at the flag positions: sign, zero, aux, parity, carry
  wire [7:0] upd_mask = {alu_mask[3], alu_mask[3], 1'b0, alu_mask[4], 1'b0, alu_mask[2],
                         1'b0, alu_mask[0]};

  // Flag write ignores instruction sequencing entirely
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) flags_ff <= 8'h02;
    else if (alu_req) flags_ff <= (flags_ff & ~upd_mask) | (calc & upd_mask);
  end

  assign busy    = st_ff != S_IDLE;
  assign done    = st_ff == S_DONE;
  assign illegal = st_ff == S_DONE && !valid_op;
  assign flags   = flags_ff;
  assign acc     = rf_ff[REG_A];
  assign pair_bc = {rf_ff[REG_B], rf_ff[REG_C]};
  assign pair_de = {rf_ff[REG_D], rf_ff[REG_E]};
  assign pair_hl = hl_addr;
  assign stack_pointer = stk_ff;
  assign states  = states_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_flags_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !alu_req |=> flags_ff == $past(flags_ff)) else $error("flags moved");
  a_zero_calc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alu_req && alu_mask[3] |=> flags_ff[FL_ZERO] == ($past(res) == 8'h00))
    else $error("zero flag wrong");
  a_move_states: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_B2 && is_move && !mv_load && !mv_store |=> states_ff == ST_MOVE_RR)
    else $error("move states wrong");
  a_dir_states: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_B2 && is_dir_ld |=> states_ff == ST_FOUR) else $error("direct states wrong");
  a_hl_order: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_MEM1 && is_hl_st |=> mem_addr == $past(mem_addr) + 16'h0001 && mem_wr)
    else $error("hl store order wrong");
  a_store_data: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mem_wr && is_ind_st |-> mem_wdata == rf_ff[REG_A]) else $error("indirect data wrong");
  a_imm_mem: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mem_wr && is_imm |-> mem_wdata == b2_ff && mem_addr == hl_addr)
    else $error("immediate store wrong");
  a_done_seq: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_IDLE && start |-> ##[2:5] done) else $error("no done");

  // ----------------------------------------
  // Flag result checks, worked out apart from the update path
  // ----------------------------------------
  a_sign_calc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alu_req && alu_mask[3] |=> flags_ff[FL_SIGN] == $past(res[7]))
    else $error("sign flag wrong");
  a_par_calc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alu_req && alu_mask[2] |=> flags_ff[FL_PAR] == ~^$past(res))
    else $error("parity flag wrong");
  a_carry_add: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alu_req && alu_mask[0] && alu_op == 2'b00
    |=> flags_ff[FL_CARRY] == ($past({1'b0, alu_a} + {1'b0, alu_b}) > 9'h0ff))
    else $error("carry flag wrong");
  a_aux_add: assert property (@(posedge clk_sys) disable iff (!rst_n)
    alu_req && alu_mask[4] && alu_op == 2'b00
    |=> flags_ff[FL_AUX] == ($past({1'b0, alu_a[3:0]} + {1'b0, alu_b[3:0]}) > 5'h0f))
    else $error("aux carry wrong");

  // ----------------------------------------
  // Transfer checks: addresses, data and state counts
  // ----------------------------------------
  a_load_hl: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_MEM1 && mv_load |-> mem_rd && mem_addr == hl_addr)
    else $error("memory load address wrong");
  a_store_hl: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_MEM1 && mv_store |-> mem_wr && mem_addr == hl_addr)
    else $error("memory store address wrong");
  a_pair_stack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_DONE && is_pair_imm && pair_select_field == PAIR_SP
    |=> stk_ff == $past({b3_ff, b2_ff})) else $error("stack pointer load wrong");
  a_hl_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_MEM2 && is_hl_ld |=> rf_ff[REG_H] == $past(mem_rdata))
    else $error("hl load high byte wrong");
  a_ind_addr: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_mem && is_ind_ld && pair_select_field == PAIR_DE
    |-> mem_rd && mem_addr == {rf_ff[REG_D], rf_ff[REG_E]}) else $error("indirect address");
  a_load_states: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_B2 && mv_load |=> states_ff == ST_TWO_CYC) else $error("load states wrong");
  a_imm_states: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_B2 && is_imm && dest_reg_field != REG_MEM |=> states_ff == ST_TWO_CYC)
    else $error("immediate states wrong");
  a_immem_states: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_B2 && is_imm && dest_reg_field == REG_MEM |=> states_ff == ST_THREE)
    else $error("immediate store states wrong");
  a_pair_states: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_B2 && is_pair_imm |=> states_ff == ST_THREE)
    else $error("pair load states wrong");
  a_store_states: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_ff == S_B2 && is_dir_st |=> states_ff == ST_FOUR)
    else $error("direct store states wrong");

  // Main scenarios reached
  c_move: cover property (@(posedge clk_sys) done && is_move);
  c_hl_load: cover property (@(posedge clk_sys) done && is_hl_ld);
  c_pair_imm: cover property (@(posedge clk_sys) done && is_pair_imm);
  c_illegal: cover property (@(posedge clk_sys) done && illegal);
endmodule

/* File: mem_model.sv */
`timescale 1ns/1ns
module mem_model (
  // Core side
  input  wire logic        clk_sys,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  output logic [7:0]       mem_rdata,
  // Operand lane driven by the bench
  input  wire logic [7:0]  imm_byte
);
  logic [7:0] mem [0:65535];
  // Same-cycle read; outside reads the operand lane shows, never a stale byte
  assign mem_rdata = mem_rd ? mem[mem_addr] : imm_byte;
  // Write lands on the edge that samples the strobe
  always @(posedge clk_sys) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
  // Varied contents, so a wrong address reads a wrong byte
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(i * 37 + (i >> 8));
    end
  end
endmodule

/* File: tb.sv */
`timescale 1ns/1ns
`define check_eq(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin \
  miscompares++; $display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb;
  import xfer_pkg::*;
  logic        clk_sys, rstn, start, alu_req, busy, done, illegal, mem_rd, mem_wr;
  logic [7:0]  opcode, alu_a, alu_b, imm_byte, mem_rdata, mem_wdata, flags, acc;
  logic [1:0]  alu_op;
  logic [4:0]  alu_mask;
  logic [3:0]  states;
  logic [15:0] mem_addr, pair_bc, pair_de, pair_hl, stack_pointer, stk_m, a16, a;
  logic [7:0]  r [0:7];
  logic [7:0]  fl_m, ra, rb;
  logic [2:0]  d, s;
  logic [1:0]  p;
  int          seed = 32'h3ce1_de9c, miscompares = 0, checks_done = 0, k;
  wire  [15:0] hl = {r[REG_H], r[REG_L]};
  data_xfer_core dut (.clk_sys(clk_sys), .rstn(rstn), .start(start), .opcode(opcode),
    .busy(busy), .done(done), .illegal(illegal), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .alu_req(alu_req),
    .alu_a(alu_a), .alu_b(alu_b), .alu_op(alu_op), .alu_mask(alu_mask), .flags(flags),
    .acc(acc), .pair_bc(pair_bc), .pair_de(pair_de), .pair_hl(pair_hl),
    .stack_pointer(stack_pointer), .states(states));
  mem_model mem_i (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .imm_byte(imm_byte));
  // Register field pick; 110 is the memory operand, so it maps to A here
  function automatic logic [2:0] pick();
    logic [2:0] v;
    v = 3'($random(seed));
    return (v == REG_MEM) ? REG_A : v;
  endfunction
  // Visible state against the model
  task automatic cmp_regs();
    `check_eq("acc", r[REG_A], acc)
    `check_eq("pair_bc", {r[REG_B], r[REG_C]}, pair_bc)
    `check_eq("pair_de", {r[REG_D], r[REG_E]}, pair_de)
    `check_eq("pair_hl", hl, pair_hl)
    `check_eq("stack_pointer", stk_m, stack_pointer)
    `check_eq("flags", fl_m, flags)
  endtask
  // One instruction; operand bytes ra, rb go out in the cycles after the start edge
  task automatic run_op(input logic [7:0] op, input int len, input int st);
    int n;
    start = 1'b1;
    opcode = op;
    @(posedge clk_sys);
    #2 start = 1'b0;
    imm_byte = ra;
    for (n = 0; n < 12; n++) begin
      @(negedge clk_sys);
      if (done === 1'b1) break;
      @(posedge clk_sys);
      #2 imm_byte = (n == 0) ? rb : 8'($random(seed));
      start = (n == 0 && len == 3); // Start while busy must be ignored
      opcode = 8'h80;
    end
    if (n == 12) miscompares++;
    `check_eq("illegal", st == -2, illegal)
    @(posedge clk_sys);
    #2 start = 1'b0;
    if (st >= 0) `check_eq("states", 4'(st), states)
    cmp_regs();
    imm_byte = 8'($random(seed));
  endtask
  // Flag model; AND leaves aux alone since its reading is not fixed
  task automatic flag_model();
    logic [8:0] res;
    logic [4:0] nib;
    if (alu_op[1]) alu_mask[4] = 1'b0;
    res = alu_op[1] ? {1'b0, alu_a & alu_b} : alu_op[0] ? {1'b0, alu_a} - {1'b0, alu_b}
        : {1'b0, alu_a} + {1'b0, alu_b};
    nib = {1'b0, alu_a[3:0]} + (alu_op[0] ? {1'b0, ~alu_b[3:0]} + 5'd1 : {1'b0, alu_b[3:0]});
    if (alu_mask[0]) fl_m[FL_CARRY] = res[8];
    if (alu_mask[2]) fl_m[FL_PAR] = ~^res[7:0];
    if (alu_mask[3]) fl_m[FL_ZERO] = (res[7:0] == 8'h00);
    if (alu_mask[3]) fl_m[FL_SIGN] = res[7];
    if (alu_mask[4]) fl_m[FL_AUX] = nib[4];
  endtask
  task automatic stop_test();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Watchdog well beyond 400 instructions of at most a dozen cycles
  initial begin
    #400_000;
    miscompares++;
    stop_test();
  end
  initial begin
    {rstn, start, alu_req, opcode, alu_a, alu_b, alu_op, alu_mask, imm_byte} = '0;
    for (k = 0; k < 8; k++) r[k] = 8'h00;
    stk_m = 16'h0000;
    fl_m = 8'h02;
    repeat (5) @(posedge clk_sys);
    #2 rstn = 1'b1;
    repeat (3) @(posedge clk_sys);
    #2 cmp_regs();
    repeat (400) begin
      ra = 8'($random(seed));
      rb = 8'($random(seed));
      d = pick();
      s = pick();
      p = {1'b0, s[0]}; // Indirect forms name only B-C or D-E
      a16 = {rb, ra};
      a = {r[{p, 1'b0}], r[{p, 1'b1}]};
      case ($unsigned($random(seed)) % 14)
        0: begin
          r[d] = r[s];
          run_op({2'b01, d, s}, 1, 5);
        end
        1: begin
          r[d] = mem_i.mem[hl];
          run_op({2'b01, d, REG_MEM}, 1, 7);
        end
        2: begin
          run_op({2'b01, REG_MEM, s}, 1, -1);
          `check_eq("mem", r[s], mem_i.mem[hl])
        end
        3: begin
          r[d] = ra;
          run_op({2'b00, d, LOW_IMM}, 2, 7);
        end
        4: begin
          run_op(OP_IMM_MEM, 2, 10);
          `check_eq("mem", ra, mem_i.mem[hl])
        end
        5: begin
          if (d[1:0] == PAIR_SP) stk_m = a16;
          else {r[{d[1:0], 1'b0}], r[{d[1:0], 1'b1}]} = a16;
          run_op({2'b00, d[1:0], LOW_PAIR}, 3, 10);
        end
        6: begin
          r[REG_A] = mem_i.mem[a16];
          run_op(OP_DIR_LD, 3, 13);
        end
        7: begin
          run_op(OP_DIR_ST, 3, 13);
          `check_eq("mem", r[REG_A], mem_i.mem[a16])
        end
        8: begin
          {r[REG_H], r[REG_L]} = {mem_i.mem[a16 + 16'h0001], mem_i.mem[a16]};
          run_op(OP_HL_LD, 3, 0);
        end
        9: begin
          run_op(OP_HL_ST, 3, 0);
          `check_eq("mem", r[REG_L], mem_i.mem[a16])
          `check_eq("mem", r[REG_H], mem_i.mem[a16 + 16'h0001])
        end
        10: begin
          r[REG_A] = mem_i.mem[a];
          run_op({2'b00, p, LOW_IND_LD}, 1, 7);
        end
        11: begin
          run_op({2'b00, p, LOW_IND_ST}, 1, 7);
          `check_eq("mem", r[REG_A], mem_i.mem[a])
        end
        12: run_op({5'b10000, s}, 1, -2);
        default: begin
          alu_a = ra;
          alu_b = rb;
          alu_op = (s[1:0] == 2'b11) ? 2'b00 : s[1:0];
          alu_mask = d[0] ? 5'h1f : 5'($random(seed));
          flag_model();
          alu_req = 1'b1;
          @(posedge clk_sys);
          #2 alu_req = 1'b0;
          @(posedge clk_sys);
          #2 cmp_regs();
        end
      endcase
    end
    stop_test();
  end
endmodule

/* File: xfer_pkg.sv */
package xfer_pkg;
  // ----------------------------------------
  // Register field codes
  // ----------------------------------------
  localparam logic [2:0] REG_B   = 3'h0;
  localparam logic [2:0] REG_C   = 3'h1;
  localparam logic [2:0] REG_D   = 3'h2;
  localparam logic [2:0] REG_E   = 3'h3;
  localparam logic [2:0] REG_H   = 3'h4;
  localparam logic [2:0] REG_L   = 3'h5;
  localparam logic [2:0] REG_MEM = 3'h6;
  localparam logic [2:0] REG_A   = 3'h7;
  localparam logic [1:0] PAIR_BC = 2'h0;
  localparam logic [1:0] PAIR_DE = 2'h1;
  localparam logic [1:0] PAIR_HL = 2'h2;
  localparam logic [1:0] PAIR_SP = 2'h3;
  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_IMM_MEM  = 8'h36;
  localparam logic [7:0] OP_DIR_LD   = 8'h3A;
  localparam logic [7:0] OP_DIR_ST   = 8'h32;
  localparam logic [7:0] OP_HL_LD    = 8'h2A;
  localparam logic [7:0] OP_HL_ST    = 8'h22;
  localparam logic [7:0] OP_STOP     = 8'h76;
  localparam logic [1:0] GRP_MOVE    = 2'h1;
  localparam logic [1:0] GRP_LOW     = 2'h0;
  localparam logic [2:0] LOW_IMM     = 3'h6;
  localparam logic [3:0] LOW_PAIR    = 4'h1;
  localparam logic [3:0] LOW_IND_LD  = 4'hA;
  localparam logic [3:0] LOW_IND_ST  = 4'h2;
  // ----------------------------------------
  // State counts per instruction
  // ----------------------------------------
  localparam logic [3:0] ST_MOVE_RR  = 4'h5;
  localparam logic [3:0] ST_TWO_CYC  = 4'h7;
  localparam logic [3:0] ST_THREE    = 4'hA;
  localparam logic [3:0] ST_FOUR     = 4'hD;
  localparam logic [3:0] ST_SHL      = 4'h0;
  localparam logic [3:0] ST_LHL_5CYC = 4'h0;
  localparam logic [4:0] ST_HL_DIR   = 5'h10;
  // Flag bit positions
  localparam int FL_CARRY = 0;
  localparam int FL_PAR   = 2;
  localparam int FL_AUX   = 4;
  localparam int FL_ZERO  = 6;
  localparam int FL_SIGN  = 7;
endpackage
